/* ifs_map.svh */
// Register offsets, field positions and reset values of the interrupt flag status block.
`ifndef IFS_MAP_SVH
`define IFS_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses)
// ==========================================================================
`define IFS_OFF_FLAGS        12'h000
`define IFS_OFF_IRQ_STATUS   12'h004
`define IFS_OFF_IRQ_MASK     12'h008
`define IFS_OFF_EVENT_IN     12'h00c

// ==========================================================================
// Flag positions
// ==========================================================================
`define IFS_BIT_UART2_TX     15
`define IFS_BIT_UART2_RX     14
`define IFS_BIT_EXT_IRQ2     13
`define IFS_BIT_TIMER5       12
`define IFS_BIT_TIMER4       11
`define IFS_BIT_OUT_CMP4     10
`define IFS_BIT_OUT_CMP3     9
`define IFS_BIT_IN_CAP8      7
`define IFS_BIT_IN_CAP7      6
`define IFS_BIT_EXT_IRQ1     4
`define IFS_BIT_CHANGE_NTF   3
`define IFS_BIT_COMPARATOR   2
`define IFS_BIT_I2C1_MASTER  1
`define IFS_BIT_I2C1_SLAVE   0

// ==========================================================================
// Masks and reset values
// ==========================================================================
`define IFS_IMPL_MASK        16'hfedf
`define IFS_FLAGS_RESET      16'h0000
`define IFS_MASK_RESET       16'h0000

`endif

/* ifs_pkg.sv */
// Types shared by the interrupt flag status block.
`default_nettype none
package ifs_pkg;
    typedef logic [15:0] ifs_word_t;
    typedef enum logic [1:0] {IFS_HTRANS_IDLE, IFS_HTRANS_BUSY, IFS_HTRANS_NONSEQ,
                              IFS_HTRANS_SEQ} ifs_htrans_t;
endpackage : ifs_pkg
`default_nettype wire

/* ifs_flag_bit.sv */
// One hardware-settable, software-writable flag bit.
`timescale 1ns/1ps
`default_nettype none
module ifs_flag_bit
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic event_pulse,
    input  wire logic write_en,
    input  wire logic write_value,
    output var  logic flag
);
    // =====================================================================
    // Flag storage
    // =====================================================================
    // An event in the same cycle as a software write wins, so no request is lost.
    always_ff @(posedge clk)
    begin
        if (reset)
            flag <= 1'b0;
        else if (event_pulse)
            flag <= 1'b1;
        else if (write_en)
            flag <= write_value;
    end
endmodule : ifs_flag_bit
`default_nettype wire

/* ifs_flag_status.sv */
// Interrupt flag status register 1 with an AHB-Lite slave and a summary interrupt.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ifs_map.svh"
// Operation
// - Flag reads one after its request, holds.
// - Zero means no request since clear/reset.
// - Bit 11 is the timer4 flag.
// - Bit 9 is the output compare3 flag.
// - Hardware sets, software reads/writes, reset clears.
// - Bits 8 and 5 ignore writes, read zero.
// - Low bits placed per fixed layout.
module ifs_flag_status
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        uart2_tx_event,
    input  wire logic        uart2_rx_event,
    input  wire logic        ext_irq2_event,
    input  wire logic        timer5_event,
    input  wire logic        timer4_event,
    input  wire logic        out_compare4_event,
    input  wire logic        out_compare3_event,
    input  wire logic        in_capture8_event,
    input  wire logic        in_capture7_event,
    input  wire logic        ext_irq1_event,
    input  wire logic        change_notify_event,
    input  wire logic        comparator_event,
    input  wire logic        i2c1_master_event,
    input  wire logic        i2c1_slave_event,
    output logic             irq
);
    // =====================================================================
    // Event gathering
    // =====================================================================
    ifs_pkg::ifs_word_t events;
    ifs_pkg::ifs_word_t interrupt_flag_status_1;
    ifs_pkg::ifs_word_t irq_status;
    ifs_pkg::ifs_word_t irq_mask;
    ifs_pkg::ifs_word_t flag_rise;
    ifs_pkg::ifs_word_t flag_prev;
    ifs_pkg::ifs_word_t flag_wdata;

    // Each source is a request from logic on this clock, so no synchroniser is
    // needed; a level held high keeps setting its flag every cycle.

    always_comb
    begin
        events                          = 16'h0000;
        events[`IFS_BIT_UART2_TX]       = uart2_tx_event;
        events[`IFS_BIT_UART2_RX]       = uart2_rx_event;
        events[`IFS_BIT_EXT_IRQ2]       = ext_irq2_event;
        events[`IFS_BIT_TIMER5]         = timer5_event;
        events[`IFS_BIT_TIMER4]         = timer4_event;
        events[`IFS_BIT_OUT_CMP4]       = out_compare4_event;
        events[`IFS_BIT_OUT_CMP3]       = out_compare3_event;
        events[`IFS_BIT_IN_CAP8]        = in_capture8_event;
        events[`IFS_BIT_IN_CAP7]        = in_capture7_event;
        events[`IFS_BIT_EXT_IRQ1]       = ext_irq1_event;
        events[`IFS_BIT_CHANGE_NTF]     = change_notify_event;
        events[`IFS_BIT_COMPARATOR]     = comparator_event;
        events[`IFS_BIT_I2C1_MASTER]    = i2c1_master_event;
        events[`IFS_BIT_I2C1_SLAVE]     = i2c1_slave_event;
    end

    // =====================================================================
    // AHB-Lite address phase capture
    // =====================================================================
    logic        dp_write;
    logic        dp_read;
    logic [11:0] dp_addr;

    // The transfer size is ignored: every register is one aligned word.
    // The slave never stalls, so the data phase is always one cycle long.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 12'h000;
        end
        else
        begin
            dp_write <= hsel && hready && htrans[1] && hwrite;
            dp_read  <= hsel && hready && htrans[1] && !hwrite;
            dp_addr  <= haddr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    wire logic flags_we  = dp_write && (dp_addr == `IFS_OFF_FLAGS);
    wire logic status_we = dp_write && (dp_addr == `IFS_OFF_IRQ_STATUS);
    wire logic mask_we   = dp_write && (dp_addr == `IFS_OFF_IRQ_MASK);
    wire logic inject_we = dp_write && (dp_addr == `IFS_OFF_EVENT_IN);

    // A software injection acts exactly like a hardware event for testing.
    ifs_pkg::ifs_word_t set_req;
    assign set_req    = (events | (inject_we ? hwdata[15:0] : 16'h0000)) & `IFS_IMPL_MASK;
    assign flag_wdata = hwdata[15:0];

    // =====================================================================
    // Flag bits
    // =====================================================================
    genvar i;
    generate
        for (i = 0; i < 16; i++)
        begin : g_flag
            if (((`IFS_IMPL_MASK >> i) & 1) != 0)
            begin : g_impl
                ifs_flag_bit u_bit
                (
                    .clk         (clk),
                    .reset       (reset),
                    .event_pulse (set_req[i]),
                    .write_en    (flags_we),
                    .write_value (flag_wdata[i]),
                    .flag        (interrupt_flag_status_1[i])
                );
            end
            else
            begin : g_unimpl
                assign interrupt_flag_status_1[i] = 1'b0;
            end
        end
    endgenerate

    // =====================================================================
    // Interrupt status, mask and output
    // =====================================================================
    // Status follows the rising edge of a flag, so a flag that software leaves set
    // does not raise the interrupt again after its status bit was cleared.
    always_ff @(posedge clk)
    begin
        if (reset)
            flag_prev <= `IFS_FLAGS_RESET;
        else
            flag_prev <= interrupt_flag_status_1;
    end

    assign flag_rise = interrupt_flag_status_1 & ~flag_prev;

    // A rising flag sets its status bit; a new rise beats a write-one clear.
    always_ff @(posedge clk)
    begin
        if (reset)
            irq_status <= 16'h0000;
        else
            irq_status <= (irq_status & ~(status_we ? hwdata[15:0] : 16'h0000))
                          | flag_rise;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq_mask <= `IFS_MASK_RESET;
        else if (mask_we)
            irq_mask <= hwdata[15:0] & `IFS_IMPL_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end

    // =====================================================================
    // Read data
    // =====================================================================
    ifs_pkg::ifs_word_t rd_word;

    // Unmapped offsets and the write-only injection port read back as zero.
    always_comb
    begin
        unique case (haddr)
            `IFS_OFF_FLAGS:      rd_word = interrupt_flag_status_1;
            `IFS_OFF_IRQ_STATUS: rd_word = irq_status;
            `IFS_OFF_IRQ_MASK:   rd_word = irq_mask;
            default:             rd_word = 16'h0000;
        endcase
    end

    // Read data is sampled at the address phase so it is registered in the data phase.
    // Outside a read data phase the bus sees zeros, so no stale flag leaks out.
    always_ff @(posedge clk)
    begin
        if (reset)
            hrdata <= 32'h0000_0000;
        else if (hsel && hready && htrans[1] && !hwrite)
            hrdata <= {16'h0000, rd_word};
        else
            hrdata <= 32'h0000_0000;
    end
endmodule : ifs_flag_status
`default_nettype wire

/* ifs_flag_status_sva.sv */
// Port assertions for the interrupt flag status block.
`timescale 1ns/1ps
`default_nettype none
module ifs_flag_status_sva
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        uart2_tx_event,
    input wire logic        timer4_event,
    input wire logic        out_compare3_event,
    input wire logic        i2c1_slave_event,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic take = hsel && hready && htrans[1];
    wire logic rd0  = take && !hwrite && haddr == 12'h000;
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_unimpl_zero: assert property (hrdata[31:16] == 16'h0 && !hrdata[8] && !hrdata[5])
        else $error("unimplemented bit read as one");
    a_idle_zero: assert property (!$past(take && !hwrite) |-> hrdata == 32'h0)
        else $error("read data not zero outside a read");
    a_timer4_bit: assert property ($past(timer4_event, 2) && $past(rd0) |-> hrdata[11])
        else $error("timer4 flag missing");
    a_cmp3_bit: assert property ($past(out_compare3_event, 2) && $past(rd0) |-> hrdata[9])
        else $error("compare3 flag missing");
    a_uart2_bit: assert property ($past(uart2_tx_event, 2) && $past(rd0) |-> hrdata[15])
        else $error("uart2 transmit flag missing");
    a_slave_bit: assert property ($past(i2c1_slave_event, 2) && $past(rd0) |-> hrdata[0])
        else $error("i2c1 slave flag missing");
    // The interrupt can only drop after software wrote something three edges before.
    a_irq_fall: assert property ($fell(irq) |-> $past(take && hwrite, 3))
        else $error("interrupt dropped without a write");
    c_irq: cover property ($rose(irq));
    c_timer4: cover property (timer4_event ##1 rd0);
    c_read: cover property (rd0 ##1 hrdata != 32'h0);
endmodule : ifs_flag_status_sva
`default_nettype wire

/* interrupt_flag_status_reg1_tb.sv */
// Self-checking testbench for the interrupt flag status block.
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_status_reg1_tb;
    logic        clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, exp_q[$];
    logic [13:0] ev = 14'h0;
    logic        hreadyout, hresp, irq;
    logic [15:0] r;
    int          bad_count = 0, check_count = 0;
    int          pos[14] = '{15, 14, 13, 12, 11, 10, 9, 7, 6, 4, 3, 2, 1, 0};
    always #5 clk = ~clk;
    ifs_flag_status dut_u
    (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .uart2_tx_event(ev[0]), .uart2_rx_event(ev[1]), .ext_irq2_event(ev[2]),
        .timer5_event(ev[3]), .timer4_event(ev[4]), .out_compare4_event(ev[5]),
        .out_compare3_event(ev[6]), .in_capture8_event(ev[7]), .in_capture7_event(ev[8]),
        .ext_irq1_event(ev[9]), .change_notify_event(ev[10]), .comparator_event(ev[11]),
        .i2c1_master_event(ev[12]), .i2c1_slave_event(ev[13])
    );
    // ==========================================================================
    // Bus tasks
    // ==========================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1)
        begin
            bad_count++;
            complete_run();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // The event stands for one edge; a read may follow at once.
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 14'h0;
    endtask : pulse
    // Read data stands only in the data phase, so it is taken at the edge ending it.
    always @(posedge clk)
    begin
        if (rd_ph && exp_q.size() > 0)
            check(hrdata, exp_q.pop_front());
        rd_ph <= hsel && hreadyout && htrans[1] && !hwrite;
    end
    // ==========================================================================
    // Scenarios
    // ==========================================================================
    initial
    begin
        void'($urandom(18195));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(12'h000, 32'h0);
        rd(12'h008, 32'h0);
        for (int i = 0; i < 14; i++)
        begin
            pulse(i);
            rd(12'h000, 32'h1 << pos[i]);
            rd(12'h000, 32'h1 << pos[i]);
            bus(1'b1, 12'h000, 32'h0);
        end
        bus(1'b1, 12'h000, 32'hffff_ffff);
        rd(12'h000, 32'h0000_fedf);
        bus(1'b1, 12'h000, 32'h0);
        rd(12'h000, 32'h0);
        repeat (4)
        begin
            r = 16'($urandom);
            bus(1'b1, 12'h000, {16'h0, r});
            rd(12'h000, {16'h0, r & 16'hfedf});
        end
        bus(1'b1, 12'h000, 32'h0);
        r = 16'($urandom);
        bus(1'b1, 12'h00c, {16'h0, r});
        rd(12'h000, {16'h0, r & 16'hfedf});
        rd(12'h00c, 32'h0);
        bus(1'b1, 12'h000, 32'h0);
        rd(12'h000, 32'h0);
        bus(1'b1, 12'h004, 32'h0000_ffff);
        rd(12'h004, 32'h0);
        bus(1'b1, 12'h008, 32'h0000_0820);
        rd(12'h008, 32'h0000_0800);
        pulse(9);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        pulse(4);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rd(12'h004, 32'h0000_0810);
        bus(1'b1, 12'h004, 32'h0000_0800);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(12'h004, 32'h0000_0010);
        rd(12'h010, 32'h0);
        bus(1'b1, 12'h000, 32'h0000_ffff);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        rd(12'h008, 32'h0);
        @(posedge clk);
        check(32'(exp_q.size()), 32'h0);
        complete_run();
    end
endmodule : interrupt_flag_status_reg1_tb
bind ifs_flag_status ifs_flag_status_sva u_sva
(
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .uart2_tx_event(uart2_tx_event), .timer4_event(timer4_event),
    .out_compare3_event(out_compare3_event), .i2c1_slave_event(i2c1_slave_event), .irq(irq)
);
`default_nettype wire
